// ==== pkg/ecd_pkg.sv ====
// Package with constants and types for the edge clock divider.
// Notes on behaviour
// RL1: Output is input clock divided by 2, 4 or 8.
// RL2: Output phase is fixed by the release moment.
// RL3: Divider reset forces outputs low without a clock.
// RL4: Outputs resume only on an input clock edge.
// RL5: Divided output is a registered clock for distribution.
// RL6: Outputs stay low until release, then toggle next edge.
package ecd_pkg;

    // Ratio select codes; the unused code falls back to divide by 8.
    localparam logic [1:0] ECD_RATIO_DIV2 = 2'h0;
    localparam logic [1:0] ECD_RATIO_DIV4 = 2'h1;
    localparam logic [1:0] ECD_RATIO_DIV8 = 2'h2;
    localparam logic [1:0] ECD_RATIO_RST = 2'h0;

    localparam int ECD_CNT_W = 3;
    localparam logic [2:0] ECD_CNT_RST = 3'h0;
    localparam logic ECD_OUT_RST = 1'b0;

    // Enabled input edges in one divided clock period, per ratio.
    localparam logic [3:0] ECD_PERIOD_DIV2 = 4'h2;
    localparam logic [3:0] ECD_PERIOD_DIV4 = 4'h4;
    localparam logic [3:0] ECD_PERIOD_DIV8 = 4'h8;

    typedef enum logic [1:0] {
        ECD_ST_HOLD = 2'h1,
        ECD_ST_RUN = 2'h2
    } ecd_state_e;

    // Control inputs that travel together.
    typedef struct packed {
        logic release_out;
        logic [1:0] ratio;
    } ecd_ctrl_s;

endpackage

// ==== src/ecd_divider.sv ====
// Edge clock divider producing a phase-aligned divided system clock.
`timescale 1ns/1ps
module ecd_divider (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic div_rst_i,
    input wire ecd_pkg::ecd_ctrl_s ctrl_i,
    output logic clk_div_o,
    output logic running_o
);

    ecd_pkg::ecd_state_e state_r;
    ecd_pkg::ecd_state_e state_nxt;
    logic [ecd_pkg::ECD_CNT_W-1:0] cnt_r;
    logic [ecd_pkg::ECD_CNT_W-1:0] cnt_nxt;
    logic [1:0] ratio_r;
    logic [1:0] ratio_nxt;
    logic out_r;
    logic out_nxt;
    logic run_r;
    logic run_nxt;

    // Selects the counter bit whose inverse is the divided clock.
    function automatic logic phase_bit(input logic [1:0] ratio,
                                       input logic [2:0] cnt);
        case (ratio)
            ecd_pkg::ECD_RATIO_DIV2: phase_bit = ~cnt[0];
            ecd_pkg::ECD_RATIO_DIV4: phase_bit = ~cnt[1];
            default: phase_bit = ~cnt[2];
        endcase
    endfunction

    // Number of enabled input edges in one divided clock period.
    function automatic logic [3:0] period_of(input logic [1:0] ratio);
        case (ratio)
            ecd_pkg::ECD_RATIO_DIV2: period_of = ecd_pkg::ECD_PERIOD_DIV2;
            ecd_pkg::ECD_RATIO_DIV4: period_of = ecd_pkg::ECD_PERIOD_DIV4;
            default: period_of = ecd_pkg::ECD_PERIOD_DIV8;
        endcase
    endfunction

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ratio_nxt = ratio_r;
        out_nxt = out_r;
        run_nxt = run_r;
        case (state_r)
            ecd_pkg::ECD_ST_HOLD: begin
                out_nxt = ecd_pkg::ECD_OUT_RST; // RL6
                cnt_nxt = ecd_pkg::ECD_CNT_RST;
                run_nxt = 1'b0;
                if (ctrl_i.release_out) begin
                    // The ratio is captured here so that the phase is
                    // fixed by the release edge alone.
                    state_nxt = ecd_pkg::ECD_ST_RUN; // RL2
                    ratio_nxt = ctrl_i.ratio;
                    out_nxt = 1'b1; // RL4
                    run_nxt = 1'b1;
                end
            end
            ecd_pkg::ECD_ST_RUN: begin
                if (!ctrl_i.release_out) begin
                    state_nxt = ecd_pkg::ECD_ST_HOLD;
                    cnt_nxt = ecd_pkg::ECD_CNT_RST;
                    out_nxt = ecd_pkg::ECD_OUT_RST;
                    run_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r + 3'h1;
                    out_nxt = phase_bit(ratio_r, cnt_nxt); // RL1
                end
            end
            default: begin
                state_nxt = ecd_pkg::ECD_ST_HOLD;
                cnt_nxt = ecd_pkg::ECD_CNT_RST;
                out_nxt = ecd_pkg::ECD_OUT_RST;
                run_nxt = 1'b0;
            end
        endcase
    end

    // The divider reset acts without the clock; the system reset is
    // synchronous.
    always_ff @(posedge clock_i or posedge div_rst_i) begin
        if (div_rst_i) begin
            state_r <= ecd_pkg::ECD_ST_HOLD; // RL3
            cnt_r <= ecd_pkg::ECD_CNT_RST;
            ratio_r <= ecd_pkg::ECD_RATIO_RST;
            out_r <= ecd_pkg::ECD_OUT_RST; // RL3
            run_r <= 1'b0;
        end else if (!rstn_i) begin
            state_r <= ecd_pkg::ECD_ST_HOLD;
            cnt_r <= ecd_pkg::ECD_CNT_RST;
            ratio_r <= ecd_pkg::ECD_RATIO_RST;
            out_r <= ecd_pkg::ECD_OUT_RST;
            run_r <= 1'b0;
        end else if (ce_i) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ratio_r <= ratio_nxt;
            out_r <= out_nxt;
            run_r <= run_nxt;
        end
    end

    // The divided clock leaves straight from a flop, glitch free.
    assign clk_div_o = out_r; // RL5
    assign running_o = run_r;

    logic go_ok;
    assign go_ok = ce_i && ctrl_i.release_out && !div_rst_i;

    // Checker helper: counts enabled edges since the divided clock last
    // rose, so that whole periods can be checked without long repeats.
    logic chk_prev_r;
    logic chk_prev_nxt;
    logic [3:0] chk_steps_r;
    logic [3:0] chk_steps_nxt;

    always_comb begin
        chk_prev_nxt = chk_prev_r;
        chk_steps_nxt = chk_steps_r;
        if (!rstn_i || !running_o) begin
            chk_prev_nxt = 1'b0;
            chk_steps_nxt = 4'h0;
        end else if (ce_i) begin
            chk_prev_nxt = clk_div_o;
            if (clk_div_o && !chk_prev_r) begin
                chk_steps_nxt = 4'h1;
            end else begin
                chk_steps_nxt = chk_steps_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge div_rst_i) begin
        if (div_rst_i) begin
            chk_prev_r <= 1'b0;
            chk_steps_r <= 4'h0;
        end else begin
            chk_prev_r <= chk_prev_nxt;
            chk_steps_r <= chk_steps_nxt;
        end
    end

    chk_rst_forces_low: assert property ( // RL3
        @(posedge clock_i) disable iff (!rstn_i)
        div_rst_i |-> (!clk_div_o && !running_o))
        else $error("divider reset did not force outputs low");

    chk_release_first_edge: assert property ( // RL6
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        (!running_o && go_ok) |=> (clk_div_o && running_o))
        else $error("output did not rise on first edge after release");

    chk_hold_stays_low: assert property ( // RL4
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        (!running_o && !ctrl_i.release_out) |=> !clk_div_o)
        else $error("output left low without release");

    chk_freeze_stable: assert property ( // RL5
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        !ce_i |=> ($stable(clk_div_o) && $stable(running_o)))
        else $error("output changed while clock enable low");

    chk_div2_toggle: assert property ( // RL1
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        (running_o && ratio_r == ecd_pkg::ECD_RATIO_DIV2 && go_ok)
        |=> (clk_div_o != $past(clk_div_o)))
        else $error("divide by 2 output did not toggle");

    chk_div8_phase: assert property ( // RL1
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        ($rose(clk_div_o) && running_o &&
         ratio_r == ecd_pkg::ECD_RATIO_DIV8 && go_ok)
        ##1 go_ok [*3] |=> (!clk_div_o && $past(clk_div_o, 2)))
        else $error("divide by 8 high phase is not four cycles");

    chk_div4_phase: assert property ( // RL2
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        (!running_o && go_ok && ctrl_i.ratio == ecd_pkg::ECD_RATIO_DIV4)
        ##1 go_ok ##1 go_ok |=> (!clk_div_o && $past(clk_div_o)))
        else $error("divide by 4 phase not aligned to release");

    chk_drop_release: assert property ( // RL4
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        (running_o && ce_i && !ctrl_i.release_out)
        |=> (!clk_div_o && !running_o))
        else $error("outputs not low after release dropped");

    chk_period_exact: assert property ( // RL1
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        (running_o && ce_i && clk_div_o && !chk_prev_r &&
         chk_steps_r != 4'h0)
        |-> (chk_steps_r == period_of(ratio_r)))
        else $error("divided clock period does not match the ratio");

    chk_level_bounded: assert property ( // RL1
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        running_o |-> (chk_steps_r <= period_of(ratio_r)))
        else $error("divided clock stayed in one period too long");

    chk_high_half: assert property ( // RL1
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        (running_o && ce_i && !clk_div_o && chk_prev_r)
        |-> (chk_steps_r == (period_of(ratio_r) >> 1)))
        else $error("divided clock high phase is not half a period");

    chk_ratio_locked: assert property ( // RL2
        @(posedge clock_i) disable iff (!rstn_i || div_rst_i)
        running_o |=> $stable(ratio_r))
        else $error("ratio changed while the divider was running");

    chk_sysrst_clears: assert property ( // RL6
        @(posedge clock_i) disable iff (div_rst_i)
        !rstn_i |=> (!clk_div_o && !running_o))
        else $error("system reset did not clear the outputs");

    cov_div2_run: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        running_o && ratio_r == ecd_pkg::ECD_RATIO_DIV2 ##1 $fell(clk_div_o));

    cov_div8_run: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        running_o && ratio_r == ecd_pkg::ECD_RATIO_DIV8 ##1 $fell(clk_div_o));

    cov_async_rst_run: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        running_o ##1 div_rst_i);

    cov_div4_run: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        running_o && ratio_r == ecd_pkg::ECD_RATIO_DIV4 ##1 $fell(clk_div_o));

    cov_freeze_run: cover property (
        @(posedge clock_i) disable iff (!rstn_i)
        running_o && !ce_i ##1 running_o && !ce_i);

endmodule

// ==== verif/ecd_clock_sink.sv ====
// Clock network model that counts divided clock rising edges.
`timescale 1ns/1ps
module ecd_clock_sink (
    input wire logic clock_i,
    input wire logic clk_div_i,
    output logic [15:0] rises_o
);
    logic last_r = 1'b0;
    initial rises_o = 16'h0;
    always @(posedge clock_i) begin
        if (clk_div_i && !last_r) rises_o <= rises_o + 16'h1;
        last_r <= clk_div_i;
    end
endmodule

// ==== verif/edge_clock_divider_test.sv ====
// Self-checking bench for the edge clock divider.
`timescale 1ns/1ps
module edge_clock_divider_test;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic div_rst_i = 1'b0;
    ecd_pkg::ecd_ctrl_s ctrl_i = '0;
    logic clk_div_o;
    logic running_o;
    logic [15:0] rises;
    logic [31:0] rng = 32'h00014e51;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    ecd_divider ecd_divider_i (.clock_i(clock_i), .rstn_i(rstn_i),
        .ce_i(ce_i), .div_rst_i(div_rst_i), .ctrl_i(ctrl_i),
        .clk_div_o(clk_div_o), .running_o(running_o));
    ecd_clock_sink ecd_clock_sink_i (.clock_i(clock_i),
        .clk_div_i(clk_div_o), .rises_o(rises));
    initial forever #25 clock_i = ~clock_i;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int div_of(input logic [1:0] code);
        return (code == 2'h0) ? 2 : (code == 2'h1) ? 4 : 8;
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        checks_done++;
        if (got !== want) begin
            mismatches++;
            $display("mismatch at %0t got %h want %h", $time, got, want);
        end
    endtask
    // Entered at a falling edge; ce and the ignored ratio vary at random.
    task automatic run_ratio(input logic [1:0] code);
        int e;
        logic [15:0] r0;
        r0 = rises;
        e = 0;
        ctrl_i = {1'b1, code};
        ce_i = 1'b1;
        #1 check(16'(clk_div_o), 16'h0);
        repeat (24) begin
            @(posedge clock_i);
            e += int'(ce_i);
            @(negedge clock_i);
            check(16'(clk_div_o), 16'((e - 1) % div_of(code) < div_of(code) / 2));
            check(16'(running_o), 16'h1);
            rng = xs(rng);
            ctrl_i.ratio = rng[1:0];
            ce_i = rng[2] | rng[3];
        end
        ctrl_i.release_out = 1'b0;
        ce_i = 1'b1;
        @(posedge clock_i);
        @(negedge clock_i);
        check(16'({clk_div_o, running_o}), 16'h0);
        check(rises - r0, 16'((e - 1) / div_of(code) + 1));
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles >= 1000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        rstn_i = 1'b1;
        check(16'({clk_div_o, running_o}), 16'h0);
        for (int c = 0; c < 4; c++) run_ratio(2'(c));
        rng = xs(rng);
        run_ratio(rng[1:0]);
        ctrl_i = {1'b1, 2'h2};
        repeat (3) @(negedge clock_i);
        div_rst_i = 1'b1;
        #1 check(16'({clk_div_o, running_o}), 16'h0);
        @(negedge clock_i);
        ctrl_i.release_out = 1'b0;
        @(negedge clock_i);
        div_rst_i = 1'b0;
        @(negedge clock_i);
        // A system reset in mid-run clears the outputs on the next edge.
        ctrl_i = {1'b1, 2'h3};
        repeat (2) @(negedge clock_i);
        check(16'(running_o), 16'h1);
        rstn_i = 1'b0;
        @(negedge clock_i);
        check(16'({clk_div_o, running_o}), 16'h0);
        rstn_i = 1'b1;
        ctrl_i.release_out = 1'b0;
        @(negedge clock_i);
        run_ratio(2'h1);
        complete_run();
    end
endmodule
